// ---- core/osc_timer_pkg.sv ----
//==========================================================================
// Purpose: Constants and types for the oscillator and divided timer clock
// Assumes: System clock of 200 MHz; oscillator modelled from it
// Notes:   Frequencies held in kHz so all counts stay integral
//
// Behaviour
// - Oscillator stays stopped by default, running only when the design enables it.
// - Raw oscillator clock output runs at a nominal 5 MHz.
// - Timer clock is oscillator divided by 128, 1024 or 1048576, fixed at build.
// - Divide ratio defaults to 128 when left unset.
// - Stop input halts the oscillator, so the timer clock halts too.
//==========================================================================
`default_nettype none

package osc_timer_pkg;

	//==========================================================
	// Timing
	//==========================================================
	localparam int SYS_FREQ_KHZ = 200000;
	localparam int OSC_FREQ_KHZ = 5000;
	localparam int OSC_HALF_CYC = SYS_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
	localparam int PHASE_W = 8;
	localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(OSC_HALF_CYC - 1);
	localparam logic [PHASE_W-1:0] PHASE_ZERO = 8'h00;

	//==========================================================
	// Divider
	//==========================================================
	localparam int unsigned DIV_128 = 128;
	localparam int unsigned DIV_1024 = 1024;
	localparam int unsigned DIV_1M = 1048576;
	localparam int unsigned DIV_DEFAULT = DIV_128;
	localparam int CNT_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

	//==========================================================
	// Synchroniser
	//==========================================================
	localparam int CTL_W = 2;
	localparam logic [CTL_W-1:0] CTL_RESET = 2'h3;

	typedef struct packed {
		logic stop;
		logic clear;
	} ctl_t;

	typedef enum logic [0:0] {
		OSC_OFF = 1'b0,
		OSC_RUN = 1'b1
	} osc_state_t;

endpackage : osc_timer_pkg

`default_nettype wire

// ---- core/osc_timer.sv ----
//==========================================================================
// Purpose: Internal oscillator model with fixed-ratio timer clock divider
// Assumes: Control inputs arrive from outside this clock domain
// Notes:   Both control inputs come up asserted, so nothing runs from reset
//==========================================================================
`default_nettype none

module osc_timer
	import osc_timer_pkg::*;
#(
	parameter int unsigned TIMER_DIV = DIV_DEFAULT
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Control from user logic
	input wire logic OSC_STOP_IN,
	input wire logic DIVIDER_CLEAR_IN,
	// Clock outputs
	output logic RAW_OSC_CLOCK_OUT,
	output logic DIVIDED_CLOCK_OUT
);

	// Timer toggles after half the ratio in raw rising edges
	localparam logic [CNT_W-1:0] TIMER_HALF = CNT_W'(TIMER_DIV / 2);
	localparam logic [CNT_W-1:0] TIMER_LAST = TIMER_HALF - CNT_ONE;

	//==========================================================
	// Input synchronisers
	//==========================================================
	logic [CTL_W-1:0] ctl_raw;
	logic [CTL_W-1:0] s1_q;
	logic [CTL_W-1:0] s2_q;
	logic [CTL_W-1:0] s3_q;
	logic [CTL_W-1:0] filt_q;
	ctl_t ctl;

	assign ctl_raw = {OSC_STOP_IN, DIVIDER_CLEAR_IN};

	// Three stages, all reset to the asserted level
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= CTL_RESET;
			s2_q <= CTL_RESET;
			s3_q <= CTL_RESET;
		end else begin
			s1_q <= ctl_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			filt_q <= CTL_RESET;
		end else begin
			for (int i = 0; i < CTL_W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					filt_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign ctl = ctl_t'(filt_q);

	//==========================================================
	// Oscillator enable
	//==========================================================
	osc_state_t state_q;
	osc_state_t state_d;

	// Filtered stop halts it next cycle; running resumes only once the filtered stop clears
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			OSC_OFF: begin
				if (!ctl.stop) begin
					state_d = OSC_RUN;
				end
			end
			OSC_RUN: begin
				if (ctl.stop) begin
					state_d = OSC_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= OSC_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	//==========================================================
	// Oscillator waveform
	//==========================================================
	logic [PHASE_W-1:0] phase_q;
	logic osc_q;
	logic osc_rise;

	assign osc_rise = (state_q == OSC_RUN) && (phase_q == PHASE_LAST) && !osc_q;

	// Half period counted in system cycles; a stop restarts low at phase zero
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			phase_q <= PHASE_ZERO;
			osc_q <= 1'b0;
		end else if (state_q == OSC_OFF) begin
			phase_q <= PHASE_ZERO;
			osc_q <= 1'b0;
		end else if (phase_q == PHASE_LAST) begin
			phase_q <= PHASE_ZERO;
			osc_q <= !osc_q;
		end else begin
			phase_q <= phase_q + 8'h01;
		end
	end

	assign RAW_OSC_CLOCK_OUT = osc_q;

	//==========================================================
	// Timer divider
	//==========================================================
	logic [CNT_W-1:0] tmr_cnt_q;
	logic tmr_q;

	// Counts only oscillator rising edges, so a stopped oscillator freezes it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tmr_cnt_q <= CNT_ZERO;
			tmr_q <= 1'b0;
		end else if (ctl.clear) begin
			tmr_cnt_q <= CNT_ZERO;
			tmr_q <= 1'b0;
		end else if (osc_rise) begin
			if (tmr_cnt_q == TIMER_LAST) begin
				tmr_cnt_q <= CNT_ZERO;
				tmr_q <= !tmr_q;
			end else begin
				tmr_cnt_q <= tmr_cnt_q + CNT_ONE;
			end
		end
	end

	assign DIVIDED_CLOCK_OUT = tmr_q;

	//==========================================================
	// Checks
	//==========================================================
	localparam int HALF_LAST = OSC_HALF_CYC - 1;
	logic [PHASE_W-1:0] hi_len_q;

	// High-time length of the raw clock, for the half period check
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			hi_len_q <= PHASE_ZERO;
		end else if (osc_q) begin
			hi_len_q <= hi_len_q + 8'h01;
		end else begin
			hi_len_q <= PHASE_ZERO;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	div_legal_a: assert property (
		TIMER_DIV == DIV_128 || TIMER_DIV == DIV_1024 || TIMER_DIV == DIV_1M)
		else $error("illegal divide ratio");

	osc_start_a: assert property ($rose(state_q == OSC_RUN) |-> $past(!ctl.stop))
		else $error("oscillator started while stop asserted");

	osc_off_a: assert property ((state_q == OSC_OFF) |=> !RAW_OSC_CLOCK_OUT)
		else $error("oscillator output active while stopped");

	osc_stop_a: assert property (ctl.stop |=> state_q == OSC_OFF)
		else $error("oscillator kept running after stop");

	osc_half_a: assert property (
		$fell(osc_q) && $past(state_q) == OSC_RUN |-> $past(hi_len_q) == PHASE_W'(HALF_LAST))
		else $error("oscillator half period wrong");

	phase_range_a: assert property (phase_q <= PHASE_LAST)
		else $error("oscillator phase out of range");

	timer_stop_a: assert property (
		(state_q == OSC_OFF && !ctl.clear) |=> $stable(DIVIDED_CLOCK_OUT))
		else $error("timer clock moved while oscillator stopped");

	count_freeze_a: assert property (
		(state_q == OSC_OFF && !ctl.clear) |=> $stable(tmr_cnt_q))
		else $error("divider counted while oscillator stopped");

	timer_clear_a: assert property (
		ctl.clear |=> !DIVIDED_CLOCK_OUT && tmr_cnt_q == CNT_ZERO)
		else $error("timer not held by clear");

	count_range_a: assert property (tmr_cnt_q <= TIMER_LAST)
		else $error("divider count past its end point");

	timer_toggle_a: assert property (
		$changed(tmr_q) && !$past(ctl.clear)
		|-> $past(osc_rise) && $past(tmr_cnt_q) == TIMER_LAST)
		else $error("timer toggled off its divide point");

	//==========================================================
	// Scenario covers
	//==========================================================
	cover property ($rose(RAW_OSC_CLOCK_OUT));
	cover property ($rose(DIVIDED_CLOCK_OUT));
	cover property ((state_q == OSC_RUN) ##1 (state_q == OSC_OFF) ##[1:400] (state_q == OSC_RUN));
	cover property ($fell(ctl.clear) ##[1:100] osc_rise);
	cover property ($fell(ctl.stop) ##[1:30] $rose(RAW_OSC_CLOCK_OUT));

endmodule : osc_timer

`default_nettype wire

// ---- sim/clk_user_model.sv ----
//==========================================================
// Purpose: User logic model consuming both clock outputs
// Assumes: Clock outputs are registered on CLK_SYS
// Notes:   Counts rising edges of each clock
//==========================================================
`default_nettype none
module clk_user_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Clocks consumed
	input wire logic raw_clk,
	input wire logic div_clk,
	// Edge counts
	output var int raw_n,
	output var int div_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic raw_q;
	logic div_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			raw_q <= 1'b0;
			div_q <= 1'b0;
			raw_n <= 0;
			div_n <= 0;
		end else begin
			raw_q <= raw_clk;
			div_q <= div_clk;
			if (raw_clk && !raw_q) raw_n <= raw_n + 1;
			if (div_clk && !div_q) div_n <= div_n + 1;
		end
	end
endmodule : clk_user_model
`default_nettype wire

// ---- sim/tb_top.sv ----
//==========================================================
// Purpose: Self-checking bench for the oscillator timer
// Assumes: Default divide ratio, 200 MHz system clock
// Notes:   Random run lengths from a bench LFSR
//==========================================================
`default_nettype none
module tb_top import osc_timer_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic stop = 1'b1;
	logic clr = 1'b1;
	logic raw;
	logic dvd;
	logic d0;
	logic [31:0] seed = 32'h0720;
	int raw_n, div_n, num_errors = 0, check_count = 0, c, r0, q0, rp;
	always #2.5 clk_sys = ~clk_sys;
	osc_timer dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .OSC_STOP_IN(stop),
		.DIVIDER_CLEAR_IN(clr), .RAW_OSC_CLOCK_OUT(raw), .DIVIDED_CLOCK_OUT(dvd));
	clk_user_model user (.clk_sys(clk_sys), .rst_n(rst_n), .raw_clk(raw), .div_clk(dvd),
		.raw_n(raw_n), .div_n(div_n));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic int raw_period();
		return SYS_FREQ_KHZ / OSC_FREQ_KHZ;
	endfunction : raw_period
	task automatic end_sim();
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("Error %s expected %0h seen %0h", what, exp, got);
			num_errors++;
		end
	endtask : check
	task automatic wait_edge(input bit use_div, input int bound, output int cyc);
		int start;
		start = use_div ? div_n : raw_n;
		cyc = 0;
		while ((use_div ? div_n : raw_n) == start) begin
			@(posedge clk_sys);
			cyc++;
			if (cyc > bound) begin
				num_errors++;
				end_sim();
			end
		end
	endtask : wait_edge
	initial begin
		rp = raw_period();
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (200) @(posedge clk_sys);
		check("raw rises while off", 0, raw_n);
		check("raw level while off", 0, raw);
		stop <= 1'b0;
		clr <= 1'b0;
		wait_edge(0, 100, c);
		for (int i = 0; i < 3; i++) begin
			wait_edge(0, 2 * rp, c);
			check("raw period", rp, c);
		end
		// One-cycle stop pulses must leave the raw period alone
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			repeat (seed[4:0]) @(posedge clk_sys);
			stop <= 1'b1;
			@(posedge clk_sys);
			stop <= 1'b0;
			wait_edge(0, 2 * rp, c);
			check("raw period glitch", rp, seed[4:0] + 1 + c);
		end
		wait_edge(1, 200 * rp, c);
		wait_edge(1, 200 * rp, c);
		check("timer period", DIV_DEFAULT * rp, c);
		wait_edge(1, 200 * rp, c);
		check("timer period", DIV_128 * rp, c);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			repeat (seed[9:0] + 1) @(posedge clk_sys);
			stop <= 1'b1;
			repeat (8) @(posedge clk_sys);
			r0 = raw_n;
			q0 = div_n;
			d0 = dvd;
			check("raw stopped", 0, raw);
			repeat (300) @(posedge clk_sys);
			check("raw rises stopped", r0, raw_n);
			check("timer rises stopped", q0, div_n);
			check("timer level held", d0, dvd);
			stop <= 1'b0;
			wait_edge(0, 2 * rp, c);
		end
		clr <= 1'b1;
		repeat (8) @(posedge clk_sys);
		q0 = div_n;
		check("timer cleared", 0, dvd);
		repeat (200 * rp) @(posedge clk_sys);
		check("timer held in clear", q0, div_n);
		check("timer low in clear", 0, dvd);
		clr <= 1'b0;
		wait_edge(1, 200 * rp, c);
		check("clear restart", 1, c >= 63 * rp && c <= 64 * rp + 8);
		// Mid-run reset: both clocks drop, then the oscillator starts again
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("raw in reset", 0, raw);
		check("timer in reset", 0, dvd);
		rst_n <= 1'b1;
		wait_edge(0, 100, c);
		wait_edge(0, 2 * rp, c);
		check("raw period after reset", rp, c);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
